// ==== dtcc_pins_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Far-side pin model
// ------------------------------------------------------------
module dtcc_pins_model (
	input  wire logic       clk,   // System clock.
	output logic      [1:0] gate,  // Gate levels, index is the timer.
	output logic      [1:0] count, // Event inputs, idle high.
	output logic      [1:0] trig   // Trigger inputs, idle high.
);
	initial begin
		gate  = 2'h3;
		count = 2'h3;
		trig  = 2'h3;
	end

	// Each level is held two cycles so that the synchroniser never misses an edge.
	task automatic fall(input int t, input bit is_trig, input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			if (is_trig) trig[t] = 1'b0; else count[t] = 1'b0;
			repeat (2) @(negedge clk);
			if (is_trig) trig[t] = 1'b1; else count[t] = 1'b1;
			repeat (2) @(negedge clk);
		end
	endtask : fall

	task automatic set_gate(input int t, input logic lvl);
		@(negedge clk);
		gate[t] = lvl;
	endtask : set_gate
endmodule : dtcc_pins_model
`default_nettype wire

// ==== dtcc_pkg.sv ====
// How it works
// - Gate bit set: count only while gate high.
// - Timer one clocks from system or timer-zero overflow.
// - Timer zero clocks from prescaled system clock, or from its count pin in event mode.
// - Output enable drives pin; cleared forces low.
// - Split bit makes two 8-bit counters stepping on the same tick.
// - Prescale register: timer one high, zero low.
// - Code n divides by 2^n; 15 as 14.
// - Overflow sets flag; it stays until cleared.
// - Writing one to overflow flag raises interrupt when enabled.
// - Trigger flag set on qualified falling trigger edge.
// - Direction bit: zero up, one down.
// - Output pulses or toggles on every overflow.
// - Trigger enable gates capture or reload edges.
// - Run bit zero halts, one runs.
// - Event mode counts falling edges of count pin.
// - Capture select picks reload or capture on trigger.
// - Timer one control mirrors timer zero control.
// - Each timer has readable, writable reload/capture register.
// - Count readable and writable as two bytes.
// - Set overflow flag requests interrupt when enabled.
package dtcc_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_PAIR_CONFIG   = 8'h89;
	localparam logic [7:0] ADDR_ZERO_COUNT_LO = 8'h8A;
	localparam logic [7:0] ADDR_RCAP_ZERO_LO  = 8'h92;
	localparam logic [7:0] ADDR_PAIR_PRESCALE = 8'h99;
	localparam logic [7:0] ADDR_ZERO_CONTROL  = 8'h9A;
	localparam logic [7:0] ADDR_TIMER_STRIDE  = 8'h02;
	localparam logic [7:0] RESET_BYTE         = 8'h00;
	localparam logic [7:0] CONFIG_WRITE_MASK  = 8'h7F;

	// ------------------------------------------------------------
	// Field positions of the shared config register
	// ------------------------------------------------------------
	localparam int CFG_GATE_ONE   = 6;
	localparam int CFG_GATE_ZERO  = 5;
	localparam int CFG_SRC_ONE    = 4;
	localparam int CFG_OE_ONE     = 3;
	localparam int CFG_SPLIT_ONE  = 2;
	localparam int CFG_OE_ZERO    = 1;
	localparam int CFG_SPLIT_ZERO = 0;

	// ------------------------------------------------------------
	// Field positions of each control register
	// ------------------------------------------------------------
	localparam int CON_OVF    = 7;
	localparam int CON_EXF    = 6;
	localparam int CON_DOWN   = 5;
	localparam int CON_TOG    = 4;
	localparam int CON_TRG_EN = 3;
	localparam int CON_RUN    = 2;
	localparam int CON_EVT    = 1;
	localparam int CON_CAP    = 0;

	// ------------------------------------------------------------
	// Prescaler
	// ------------------------------------------------------------
	localparam int         PRE_WIDTH    = 14;
	localparam logic [3:0] PRE_MAX_CODE = 4'hE;
	localparam int         PRE_ONE_LSB  = 4;

	// ------------------------------------------------------------
	// Counter extremes
	// ------------------------------------------------------------
	localparam logic [7:0] BYTE_MAX = 8'hFF;
	localparam logic [7:0] BYTE_MIN = 8'h00;

endpackage : dtcc_pkg

// ==== dtcc_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module dtcc_top
	import dtcc_pkg::*;
(
	input  wire logic       clk,                    // System clock, 50 MHz.
	input  wire logic       reset,                  // Synchronous reset, active high.
	input  wire logic [7:0] sfr_addr,               // Register address.
	input  wire logic       sfr_wr,                 // Write strobe, one cycle.
	input  wire logic [7:0] sfr_wdata,              // Write data.
	input  wire logic       sfr_rd,                 // Read strobe, one cycle.
	output logic      [7:0] sfr_rdata,              // Read data, valid the cycle after sfr_rd.
	input  wire logic       gate_pin_zero,          // Gate pin for timer zero.
	input  wire logic       gate_pin_one,           // Gate pin for timer one.
	input  wire logic       timer_zero_count_pin,   // Event input for timer zero.
	input  wire logic       timer_one_count_pin,    // Event input for timer one.
	input  wire logic       timer_zero_trigger_pin, // Reload or capture trigger, timer zero.
	input  wire logic       timer_one_trigger_pin,  // Reload or capture trigger, timer one.
	input  wire logic       timer_zero_int_enable,  // Interrupt enable, timer zero.
	input  wire logic       timer_one_int_enable,   // Interrupt enable, timer one.
	output logic            timer_zero_out,         // Timer zero output pin level.
	output logic            timer_one_out,          // Timer one output pin level.
	output logic            timer_zero_out_en,      // Timer zero pin drive enable.
	output logic            timer_one_out_en,       // Timer one pin drive enable.
	output logic            timer_zero_irq,         // Timer zero interrupt request.
	output logic            timer_one_irq           // Timer one interrupt request.
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0]                      cfg;
		logic [7:0]                      pre;
		logic [1:0][7:0]                 con;
		logic [1:0][15:0]                cnt;
		logic [1:0][15:0]                rcap;
		logic [1:0][PRE_WIDTH-1:0]       div;
		logic [1:0]                      gate_s1;
		logic [1:0]                      gate_s2;
		logic [1:0]                      evt_s1;
		logic [1:0]                      evt_s2;
		logic [1:0]                      evt_s3;
		logic [1:0]                      trg_s1;
		logic [1:0]                      trg_s2;
		logic [1:0]                      trg_s3;
		logic [1:0]                      level;
		logic [1:0]                      out;
		logic [1:0]                      oe;
		logic [1:0]                      irq;
		logic [7:0]                      rdata;
	} dtcc_state_s;

	dtcc_state_s                s;
	dtcc_state_s                next_s;
	logic [1:0]                 ovf_ev;
	logic [1:0]                 tick;
	logic [1:0]                 trg_fall;
	logic [1:0]                 int_en;
	logic [3:0]                 code;
	logic [PRE_WIDTH-1:0]       mask;
	logic                       run_ok;
	logic                       base;
	logic                       split;
	logic                       down;
	logic                       lo_wrap;
	logic                       hi_wrap;
	logic [7:0]                 lo;
	logic [7:0]                 hi;
	logic [7:0]                 a_cnt;
	logic [7:0]                 a_rcap;
	logic [7:0]                 a_con;

	assign int_en = {timer_one_int_enable, timer_zero_int_enable};

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		next_s   = s;
		ovf_ev   = 2'b00;
		tick     = 2'b00;
		trg_fall = 2'b00;
		code     = 4'h0;
		mask     = '0;
		run_ok   = 1'b0;
		base     = 1'b0;
		split    = 1'b0;
		down     = 1'b0;
		lo_wrap  = 1'b0;
		hi_wrap  = 1'b0;
		lo       = 8'h00;
		hi       = 8'h00;
		a_cnt    = 8'h00;
		a_rcap   = 8'h00;
		a_con    = 8'h00;

		// The first stage of each synchroniser feeds only the second.
		next_s.gate_s1 = {gate_pin_one, gate_pin_zero};
		next_s.gate_s2 = s.gate_s1;
		next_s.evt_s1  = {timer_one_count_pin, timer_zero_count_pin};
		next_s.evt_s2  = s.evt_s1;
		next_s.evt_s3  = s.evt_s2;
		next_s.trg_s1  = {timer_one_trigger_pin, timer_zero_trigger_pin};
		next_s.trg_s2  = s.trg_s1;
		next_s.trg_s3  = s.trg_s2;

		// Shared registers.
		if (sfr_wr && sfr_addr == ADDR_PAIR_CONFIG) begin
			next_s.cfg = sfr_wdata & CONFIG_WRITE_MASK;
		end
		if (sfr_wr && sfr_addr == ADDR_PAIR_PRESCALE) begin
			next_s.pre = sfr_wdata;
		end

		// Timer zero is handled first so that its overflow can clock timer one.
		for (int t = 0; t < 2; t++) begin
			a_cnt  = ADDR_ZERO_COUNT_LO + 8'(t * 2);
			a_rcap = ADDR_RCAP_ZERO_LO + 8'(t * 2);
			a_con  = ADDR_ZERO_CONTROL + 8'(t);
			split  = (t == 1) ? s.cfg[CFG_SPLIT_ONE] : s.cfg[CFG_SPLIT_ZERO];
			down   = s.con[t][CON_DOWN];
			code   = (t == 1) ? s.pre[PRE_ONE_LSB +: 4] : s.pre[3:0];
			if (code > PRE_MAX_CODE) begin
				code = PRE_MAX_CODE;
			end
			mask = (PRE_WIDTH'(1) << code) - PRE_WIDTH'(1);

			run_ok = s.con[t][CON_RUN];
			if ((t == 1) ? s.cfg[CFG_GATE_ONE] : s.cfg[CFG_GATE_ZERO]) begin
				run_ok = run_ok & s.gate_s2[t];
			end
			// Timer one may chain on timer zero; timer zero has no alternative.
			base = (t == 1 && s.cfg[CFG_SRC_ONE]) ? ovf_ev[0] : 1'b1;

			if (s.con[t][CON_EVT]) begin
				tick[t] = run_ok & s.evt_s3[t] & ~s.evt_s2[t];
			end else if (run_ok && base) begin
				next_s.div[t] = s.div[t] + PRE_WIDTH'(1);
				tick[t]       = (s.div[t] & mask) == mask;
			end

			// The high byte steps on a low-byte wrap in 16-bit mode, on every tick when split.
			lo      = s.cnt[t][7:0];
			hi      = s.cnt[t][15:8];
			lo_wrap = tick[t] & (down ? (lo == BYTE_MIN) : (lo == BYTE_MAX));
			hi_wrap = (split ? tick[t] : lo_wrap) & (down ? (hi == BYTE_MIN) : (hi == BYTE_MAX));
			if (tick[t]) begin
				next_s.cnt[t][7:0] = down ? lo - 8'h01 : lo + 8'h01;
			end
			if (split ? tick[t] : lo_wrap) begin
				next_s.cnt[t][15:8] = down ? hi - 8'h01 : hi + 8'h01;
			end
			ovf_ev[t] = split ? (lo_wrap | hi_wrap) : hi_wrap;

			// Trigger edge: reload wins over counting in the same cycle.
			trg_fall[t] = s.con[t][CON_TRG_EN] & s.trg_s3[t] & ~s.trg_s2[t];
			if (trg_fall[t] && !s.con[t][CON_CAP]) begin
				next_s.cnt[t] = s.rcap[t];
				ovf_ev[t]     = 1'b0;
			end

			// Software access to count and reload/capture bytes.
			if (sfr_wr && sfr_addr == a_cnt) begin
				next_s.cnt[t][7:0] = sfr_wdata;
			end
			if (sfr_wr && sfr_addr == a_cnt + 8'h01) begin
				next_s.cnt[t][15:8] = sfr_wdata;
			end
			if (sfr_wr && sfr_addr == a_rcap) begin
				next_s.rcap[t][7:0] = sfr_wdata;
			end
			if (sfr_wr && sfr_addr == a_rcap + 8'h01) begin
				next_s.rcap[t][15:8] = sfr_wdata;
			end
			// A capture beats a software write of the same register.
			if (trg_fall[t] && s.con[t][CON_CAP]) begin
				next_s.rcap[t] = s.cnt[t];
			end

			// Control register: both timers share one layout. Hardware sets win.
			if (sfr_wr && sfr_addr == a_con) begin
				next_s.con[t] = sfr_wdata;
			end
			next_s.con[t][CON_OVF] = next_s.con[t][CON_OVF] | ovf_ev[t];
			next_s.con[t][CON_EXF] = next_s.con[t][CON_EXF] | trg_fall[t];

			// Output stage.
			next_s.oe[t] = (t == 1) ? next_s.cfg[CFG_OE_ONE] : next_s.cfg[CFG_OE_ZERO];
			if (s.con[t][CON_TOG]) begin
				next_s.level[t] = s.level[t] ^ ovf_ev[t];
				next_s.out[t]   = next_s.oe[t] & next_s.level[t];
			end else begin
				next_s.out[t] = next_s.oe[t] & ovf_ev[t];
			end

			next_s.irq[t] = next_s.con[t][CON_OVF] & int_en[t];
		end

		// Read port: unmapped addresses return zero.
		if (sfr_rd) begin
			case (sfr_addr)
				ADDR_PAIR_CONFIG:                           next_s.rdata = s.cfg;
				ADDR_PAIR_PRESCALE:                         next_s.rdata = s.pre;
				ADDR_ZERO_CONTROL:                          next_s.rdata = s.con[0];
				ADDR_ZERO_CONTROL + 8'h01:                  next_s.rdata = s.con[1];
				ADDR_ZERO_COUNT_LO:                         next_s.rdata = s.cnt[0][7:0];
				ADDR_ZERO_COUNT_LO + 8'h01:                 next_s.rdata = s.cnt[0][15:8];
				ADDR_ZERO_COUNT_LO + ADDR_TIMER_STRIDE:     next_s.rdata = s.cnt[1][7:0];
				ADDR_ZERO_COUNT_LO + 8'h03:                 next_s.rdata = s.cnt[1][15:8];
				ADDR_RCAP_ZERO_LO:                          next_s.rdata = s.rcap[0][7:0];
				ADDR_RCAP_ZERO_LO + 8'h01:                  next_s.rdata = s.rcap[0][15:8];
				ADDR_RCAP_ZERO_LO + ADDR_TIMER_STRIDE:      next_s.rdata = s.rcap[1][7:0];
				ADDR_RCAP_ZERO_LO + 8'h03:                  next_s.rdata = s.rcap[1][15:8];
				default:                                    next_s.rdata = RESET_BYTE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign sfr_rdata         = s.rdata;
	assign timer_zero_out    = s.out[0];
	assign timer_one_out     = s.out[1];
	assign timer_zero_out_en = s.oe[0];
	assign timer_one_out_en  = s.oe[1];
	assign timer_zero_irq    = s.irq[0];
	assign timer_one_irq     = s.irq[1];

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	chk_gate_low_hold: assert property (
		(s.cfg[CFG_GATE_ZERO] && !s.gate_s2[0] && !sfr_wr && !trg_fall[0]) |=> $stable(s.cnt[0])
	) else $error("Timer zero advanced while its gate was low.");

	chk_chain_source: assert property (
		(s.cfg[CFG_SRC_ONE] && !s.con[1][CON_EVT] && !ovf_ev[0] && !sfr_wr && !trg_fall[1])
		|=> $stable(s.cnt[1])
	) else $error("Chained timer one moved without a timer zero overflow.");

	chk_undivided_tick: assert property (
		(s.pre[3:0] == 4'h0 && s.con[0][CON_RUN] && !s.con[0][CON_EVT] && !s.cfg[CFG_GATE_ZERO]) |-> tick[0]
	) else $error("Undivided timer zero missed a system clock tick.");

	chk_divide_by_two: assert property (
		(tick[0] && s.pre[3:0] == 4'h1 && !s.con[0][CON_EVT]) |=> !tick[0]
	) else $error("Divide-by-two prescaler ticked twice in a row.");

	chk_output_off: assert property (
		!s.cfg[CFG_OE_ZERO] && !sfr_wr |=> !timer_zero_out && !timer_zero_out_en
	) else $error("Timer zero pin driven with its output disabled.");

	chk_ovf_sticky: assert property (
		ovf_ev[0] ##1 !(sfr_wr && sfr_addr == ADDR_ZERO_CONTROL) |-> s.con[0][CON_OVF]
	) else $error("Overflow flag not held after an overflow.");

	chk_trig_flag: assert property (
		trg_fall[1] |=> s.con[1][CON_EXF]
	) else $error("Trigger flag of timer one not set by a trigger edge.");

	chk_count_down: assert property (
		(tick[0] && s.con[0][CON_DOWN] && !s.cfg[CFG_SPLIT_ZERO] && !sfr_wr && !trg_fall[0])
		|=> s.cnt[0] == $past(s.cnt[0]) - 16'h0001
	) else $error("Timer zero did not step down by one.");

	chk_pulse_out: assert property (
		(ovf_ev[0] && !s.con[0][CON_TOG] && s.cfg[CFG_OE_ZERO] && !sfr_wr) |=> timer_zero_out
	) else $error("Pulse output missing after overflow.");

	chk_halt_hold: assert property (
		(!s.con[1][CON_RUN] && !sfr_wr && !trg_fall[1]) |=> $stable(s.cnt[1])
	) else $error("Stopped timer one changed its count.");

	chk_capture_value: assert property (
		(trg_fall[0] && s.con[0][CON_CAP]) |=> s.rcap[0] == $past(s.cnt[0])
	) else $error("Capture did not store the current count.");

	chk_reload_value: assert property (
		(trg_fall[0] && !s.con[0][CON_CAP] && !sfr_wr) |=> s.cnt[0] == $past(s.rcap[0])
	) else $error("Reload did not load the reload value.");

	chk_irq_follow: assert property (
		(s.con[0][CON_OVF] && $past(int_en[0])) |-> timer_zero_irq
	) else $error("Enabled overflow flag without an interrupt request.");

	chk_trig_ignored: assert property (
		(!s.con[0][CON_TRG_EN] && s.con[0][CON_CAP] && !sfr_wr)
		|=> $stable(s.rcap[0])
	) else $error("Timer zero captured with its trigger disabled.");

	chk_event_step: assert property (
		(s.con[1][CON_EVT] && s.con[1][CON_RUN] && s.evt_s3[1] && !s.evt_s2[1] && !s.con[1][CON_DOWN]
			&& !s.cfg[CFG_SPLIT_ONE] && !s.cfg[CFG_GATE_ONE] && !sfr_wr && !trg_fall[1])
		|=> s.cnt[1] == $past(s.cnt[1]) + 16'h0001
	) else $error("Timer one missed a count pin edge.");

	chk_split_low_wrap: assert property (
		(s.cfg[CFG_SPLIT_ZERO] && tick[0] && !s.con[0][CON_DOWN] && s.cnt[0][7:0] == BYTE_MAX && !trg_fall[0])
		|-> ovf_ev[0]
	) else $error("Split low byte wrapped without an overflow.");

	chk_down_wrap: assert property (
		(tick[0] && s.con[0][CON_DOWN] && !s.cfg[CFG_SPLIT_ZERO] && s.cnt[0] == 16'h0000 && !trg_fall[0])
		|-> ovf_ev[0]
	) else $error("Down count wrap did not raise an overflow.");

	chk_toggle_out: assert property (
		(ovf_ev[1] && s.con[1][CON_TOG] && s.cfg[CFG_OE_ONE] && !sfr_wr)
		|=> timer_one_out != $past(s.level[1])
	) else $error("Timer one output did not toggle on overflow.");

	chk_irq_masked: assert property (
		!$past(int_en[1]) |-> !timer_one_irq
	) else $error("Timer one interrupt raised while disabled.");

	chk_trig_sticky: assert property (
		(s.con[0][CON_EXF] && !sfr_wr) |=> s.con[0][CON_EXF]
	) else $error("Trigger flag of timer zero cleared by itself.");

	// Toggle coverage shows the level output is exercised, not only pulses.
	cov_toggle_wrap: cover property (ovf_ev[1] && s.con[1][CON_TOG]);
	cov_overflow_up: cover property (ovf_ev[0] && !s.con[0][CON_DOWN]);
	cov_split_wrap:  cover property (ovf_ev[1] && s.cfg[CFG_SPLIT_ONE]);
	cov_capture:     cover property (trg_fall[0] && s.con[0][CON_CAP]);
	cov_chained:     cover property (tick[1] && s.cfg[CFG_SRC_ONE]);

endmodule : dtcc_top

`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import dtcc_pkg::*;
	localparam logic [7:0] RUN = 8'h01 << CON_RUN;
	localparam logic [7:0] EVT = 8'h01 << CON_EVT;
	localparam logic [7:0] DWN = 8'h01 << CON_DOWN;
	localparam logic [7:0] TOG = 8'h01 << CON_TOG;
	localparam logic [7:0] TEN = 8'h01 << CON_TRG_EN;
	localparam logic [7:0] CAP = 8'h01 << CON_CAP;
	localparam logic [7:0] EXF = 8'h01 << CON_EXF;
	logic        clk, reset, sfr_wr, sfr_rd, dn, sp;
	logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, d;
	logic [1:0]  gate, cnt, trg, out, oe, irq, ie;
	logic [15:0] v, w, r;
	logic [16:0] e;
	int          bad_count, n_checks, n, tt;
	int          pulses[2];
	logic [7:0]  ca[2] = '{ADDR_ZERO_COUNT_LO, ADDR_ZERO_COUNT_LO + ADDR_TIMER_STRIDE};
	logic [7:0]  ra[2] = '{ADDR_RCAP_ZERO_LO, ADDR_RCAP_ZERO_LO + ADDR_TIMER_STRIDE};
	logic [7:0]  ka[2] = '{ADDR_ZERO_CONTROL, ADDR_ZERO_CONTROL + 8'h01};
	logic [7:0]  rl[5] = '{ADDR_PAIR_CONFIG, ADDR_PAIR_PRESCALE, ADDR_ZERO_CONTROL, ADDR_ZERO_CONTROL + 8'h01, 8'h80};
	int          oeb[2] = '{CFG_OE_ZERO, CFG_OE_ONE};
	int          gtb[2] = '{CFG_GATE_ZERO, CFG_GATE_ONE};
	int          spb[2] = '{CFG_SPLIT_ZERO, CFG_SPLIT_ONE};

	dtcc_top u_dut (
		.clk                    (clk),
		.reset                  (reset),
		.sfr_addr               (sfr_addr),
		.sfr_wr                 (sfr_wr),
		.sfr_wdata              (sfr_wdata),
		.sfr_rd                 (sfr_rd),
		.sfr_rdata              (sfr_rdata),
		.gate_pin_zero          (gate[0]),
		.gate_pin_one           (gate[1]),
		.timer_zero_count_pin   (cnt[0]),
		.timer_one_count_pin    (cnt[1]),
		.timer_zero_trigger_pin (trg[0]),
		.timer_one_trigger_pin  (trg[1]),
		.timer_zero_int_enable  (ie[0]),
		.timer_one_int_enable   (ie[1]),
		.timer_zero_out         (out[0]),
		.timer_one_out          (out[1]),
		.timer_zero_out_en      (oe[0]),
		.timer_one_out_en       (oe[1]),
		.timer_zero_irq         (irq[0]),
		.timer_one_irq          (irq[1])
	);
	dtcc_pins_model u_pins (.clk(clk), .gate(gate), .count(cnt), .trig(trg));

	// ------------------------------------------------------------
	// Bus tasks and expectations
	// ------------------------------------------------------------
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] x);
		@(negedge clk);
		sfr_addr  = a;
		sfr_wdata = x;
		sfr_wr    = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
	endtask : wr

	// Read data is registered and held, so it is taken one full cycle late.
	task automatic rd(input logic [7:0] a);
		@(negedge clk);
		sfr_addr = a;
		sfr_rd   = 1'b1;
		@(negedge clk);
		sfr_rd = 1'b0;
		@(negedge clk);
		d = sfr_rdata;
	endtask : rd

	task automatic wr16(input logic [7:0] a, input logic [15:0] x);
		wr(a, x[7:0]);
		wr(a + 8'h01, x[15:8]);
	endtask : wr16

	task automatic rd16(input logic [7:0] a);
		rd(a);
		r[7:0] = d;
		rd(a + 8'h01);
		r[15:8] = d;
	endtask : rd16

	task automatic spin(input int t, input int c);
		wr(ka[t], RUN);
		repeat (c) @(negedge clk);
		wr(ka[t], RESET_BYTE);
		rd16(ca[t]);
	endtask : spin

	function automatic logic [16:0] expect_cnt(input logic [15:0] c, input logic down, input logic split, input int k);
		logic [7:0] s;
		logic [7:0] b;
		logic       ov;
		s  = down ? 8'hFF : 8'h01;
		b  = down ? 8'h00 : 8'hFF;
		ov = 1'b0;
		for (int i = 0; i < k; i++) begin
			if (split) begin
				ov = ov | c[7:0] == b | c[15:8] == b;
				c  = {c[15:8] + s, c[7:0] + s};
			end else begin
				ov = ov | c == {b, b};
				c  = c + {{8{down}}, s};
			end
		end
		return {ov, c};
	endfunction : expect_cnt

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : stop_test

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk) begin
		pulses[0] <= pulses[0] + int'(out[0]);
		pulses[1] <= pulses[1] + int'(out[1]);
	end

	initial begin
		repeat (40000) @(posedge clk);
		bad_count++;
		stop_test();
	end

	initial begin
		void'($urandom(32'hB16C8EE4));
		reset     = 1'b1;
		sfr_wr    = 1'b0;
		sfr_rd    = 1'b0;
		sfr_addr  = 8'h00;
		sfr_wdata = 8'h00;
		ie        = 2'h3;
		repeat (5) @(negedge clk);
		reset = 1'b0;
		foreach (rl[i]) begin
			rd(rl[i]);
			check(16'(d), 16'(RESET_BYTE));
		end
		wr(ADDR_PAIR_CONFIG, 8'hFF);
		rd(ADDR_PAIR_CONFIG);
		check(16'(d), 16'(CONFIG_WRITE_MASK));
		v = 16'($urandom);
		wr(ADDR_PAIR_PRESCALE, v[7:0]);
		rd(ADDR_PAIR_PRESCALE);
		check(16'(d), 16'(v[7:0]));
		wr(ADDR_PAIR_CONFIG, RESET_BYTE);
		wr(ADDR_PAIR_PRESCALE, RESET_BYTE);
		for (int t = 0; t < 2; t++) begin
			v  = 16'($urandom) & ~16'(RUN);
			ie = 2'($urandom);
			wr(ka[t], v[7:0]);
			rd(ka[t]);
			check(16'(d), 16'(v[7:0]));
			check(16'(irq[t]), 16'(v[CON_OVF] & ie[t]));
			wr(ka[t], RESET_BYTE);
		end
		ie = 2'h3;
		$display("test registers done");
		for (int t = 0; t < 2; t++) for (int m = 0; m < 2; m++) begin
			wr(ADDR_PAIR_CONFIG, 8'h01 << oeb[t]);
			wr16(ca[t], (m == 1) ? 16'h0003 : 16'hFFFC);
			w[0]      = out[t];
			pulses[t] = 0;
			wr(ka[t], RUN | ((m == 1) ? (DWN | TOG) : 8'h00));
			repeat (8) @(negedge clk);
			rd(ka[t]);
			check(16'(d[CON_OVF]), 16'h0001);
			check(16'(irq[t]), 16'h0001);
			check(16'(oe[t]), 16'h0001);
			check(16'(out[t]), {15'h0000, (m == 1) ? !w[0] : 1'b0});
			if (m == 0) check(16'(pulses[t]), 16'h0001);
			wr(ADDR_PAIR_CONFIG, RESET_BYTE);
			wr(ka[t], RESET_BYTE);
			@(negedge clk);
			check(16'(out[t]), 16'h0000);
			check(16'(irq[t]), 16'h0000);
		end
		$display("test overflow done");
		wr(ADDR_PAIR_CONFIG, 8'h01 << CFG_SRC_ONE);
		wr16(ca[1], 16'h0000);
		wr16(ca[0], 16'hFFFE);
		wr(ka[1], RUN);
		wr(ka[0], RUN);
		repeat (8) @(negedge clk);
		wr(ka[0], RESET_BYTE);
		wr(ka[1], RESET_BYTE);
		rd16(ca[1]);
		check(r, 16'h0001);
		wr(ADDR_PAIR_CONFIG, RESET_BYTE);
		for (int t = 0; t < 2; t++) begin
			n = $urandom_range(4, 1);
			wr(ADDR_PAIR_PRESCALE, 8'(n) << (4 * t));
			wr16(ca[t], 16'h0000);
			spin(t, 32 << n);
			check(16'(r >= 16'h001F && r <= 16'h0022), 16'h0001);
		end
		wr(ADDR_PAIR_PRESCALE, RESET_BYTE);
		$display("test clocking done");
		for (int t = 0; t < 2; t++) begin
			wr(ADDR_PAIR_CONFIG, 8'h01 << gtb[t]);
			u_pins.set_gate(t, 1'b0);
			wr16(ca[t], 16'h0000);
			spin(t, 20);
			check(r, 16'h0000);
			u_pins.set_gate(t, 1'b1);
			spin(t, 20);
			check(16'(r != 16'h0000), 16'h0001);
		end
		$display("test gating done");
		for (int k = 0; k < 6; k++) begin
			tt = k % 2;
			dn = 1'($urandom);
			sp = 1'($urandom);
			n  = $urandom_range(4, 1);
			v  = (k < 2) ? (16'hFFFE ^ {16{dn}}) : 16'($urandom);
			wr(ADDR_PAIR_CONFIG, 8'(sp) << spb[tt]);
			wr16(ca[tt], v);
			wr(ka[tt], RUN | EVT | (dn ? DWN : 8'h00));
			u_pins.fall(tt, 1'b0, n);
			e = expect_cnt(v, dn, sp, n);
			rd(ka[tt]);
			check(16'(d[CON_OVF]), 16'(e[16]));
			rd16(ca[tt]);
			check(r, e[15:0]);
			wr(ka[tt], RESET_BYTE);
		end
		wr(ADDR_PAIR_CONFIG, RESET_BYTE);
		$display("test events done");
		for (int t = 0; t < 2; t++) begin
			v = 16'($urandom);
			w = 16'($urandom);
			wr16(ra[t], v);
			wr16(ca[t], w);
			wr(ka[t], TEN);
			u_pins.fall(t, 1'b1, 1);
			rd16(ca[t]);
			check(r, v);
			rd(ka[t]);
			check(16'(d), 16'(TEN | EXF));
			wr(ka[t], TEN | CAP);
			wr16(ca[t], w);
			u_pins.fall(t, 1'b1, 1);
			rd16(ra[t]);
			check(r, w);
			wr(ka[t], CAP);
			wr16(ca[t], ~w);
			u_pins.fall(t, 1'b1, 1);
			rd16(ra[t]);
			check(r, w);
			rd(ka[t]);
			check(16'(d), 16'(CAP));
			wr(ka[t], RESET_BYTE);
		end
		$display("test trigger done");
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
